// ==== verilog/etpm_cfg.svh ====
// How it works
// (R01) One elapsed timer serves every program table; any reset affects all readers.
// (R02) Timer steps every 0.125 s, saturates at 8191.875 s, read in eighths.
// (R03) Compile-and-run code clears the timer; compile-only code leaves it running.
// (R04) Timer command location 0 resets the timer; nonzero stores elapsed there.
// (R05) Period engine times requested cycles; raw resolution 60 ns or finer.
// (R06) Each repetition gives up after the timeout and stores -99999.
// (R07) Software gives timeout in 0.01 s units, covering cycles plus 1.5.
// (R08) Option bit clear returns period in us; set returns frequency in kHz.
// (R09) Range codes 1 to 4 allow 8, 20, 50, 200 kHz inputs.
// (R10) One result per repetition into consecutive locations from the destination.
// (R11) Frequency is one thousand over period in us, before scaling.
// Purpose: Constants for the elapsed timer and period meter
// Assumes: 125 MHz aclk
// Notes:   Results are milli-units: ns for period, Hz for frequency
`ifndef ETPM_CFG_SVH
`define ETPM_CFG_SVH
`define ETPM_CLK_NS        8
`define ETPM_RES_NS        60
`define ETPM_TIMER_STEP_NS 125000000
`define ETPM_TIMER_MAX     16'hffff
`define ETPM_TMO_UNIT_NS   10000000
`define ETPM_TMO_MAX       16'hffff
`define ETPM_ERR_VAL       32'hfffe7961
`define ETPM_NS_PER_S      40'h003b9aca00
`define ETPM_MULT_FRAC     16
`define ETPM_MULT_RST      32'h00010000
`define ETPM_FMAX_R1_KHZ   8
`define ETPM_FMAX_R2_KHZ   20
`define ETPM_FMAX_R3_KHZ   50
`define ETPM_FMAX_R4_KHZ   200
`define ETPM_FILT(khz)     (1000000 / (khz) / 4 / `ETPM_CLK_NS)
`define ETPM_RANGE_1       4'h1
`define ETPM_RANGE_2       4'h2
`define ETPM_RANGE_3       4'h3
`define ETPM_RANGE_4       4'h4
`define ETPM_COMPILE_RUN   32'h00000000
`define ETPM_COMPILE_KEEP  32'h00000006
`define ETPM_A_CTRL        12'h000
`define ETPM_A_CFG         12'h004
`define ETPM_A_CYC         12'h008
`define ETPM_A_TMO         12'h00c
`define ETPM_A_DEST        12'h010
`define ETPM_A_MULT        12'h014
`define ETPM_A_OFFS        12'h018
`define ETPM_A_TCMD        12'h01c
`define ETPM_A_COMP        12'h020
`define ETPM_A_ELAP        12'h024
`define ETPM_A_STAT        12'h028
`define ETPM_A_MASK        12'h02c
`define ETPM_MEM_BASE      12'h100
`define ETPM_MEM_MASK      12'hfc0
`define ETPM_LOCS          16
`define ETPM_CFG_MASK      32'h00001fff
`define ETPM_CFG_RST       32'h00000101
`define ETPM_CTRL_GO       0
`define ETPM_ST_DONE       0
`define ETPM_ST_TMO        1
`define ETPM_ST_BAD        2
`define ETPM_RESP_OKAY     2'b00
`define ETPM_RESP_SLVERR   2'b10
`endif

// ==== verilog/etpm_pkg.sv ====
// Purpose: Types for the elapsed timer and period meter
// Assumes: Used by qualified name only
// Notes:   Field layout of the measurement word is the struct order
package etpm_pkg;
  typedef struct packed {
    logic [18:0] rsv;
    logic        freq;
    logic [3:0]  range;
    logic [7:0]  reps;
  } etpm_mcfg_t;

  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_ARM   = 7'b0000010,
    S_COUNT = 7'b0000100,
    S_DIV1  = 7'b0001000,
    S_DIV2  = 7'b0010000,
    S_SCALE = 7'b0100000,
    S_STORE = 7'b1000000
  } etpm_state_t;
endpackage : etpm_pkg

// ==== verilog/etpm_tick_timer.sv ====
// Purpose: Elapsed timer in eighths of a second
// Assumes: STEP_CYC clock cycles per step
// Notes:   Saturates rather than wrapping so a stale read is never small
`timescale 1ns/1ps
`include "etpm_cfg.svh"
module etpm_tick_timer #(
  parameter int STEP_CYC = 1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        clear,
  output logic      [15:0] count
);
  logic [23:0] pre;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre   <= 24'h0;
      count <= 16'h0;
    end else if (ce) begin
      if (clear) begin
        pre   <= 24'h0;
        count <= 16'h0;
      end else if (pre == 24'(STEP_CYC - 1)) begin
        pre <= 24'h0;
        if (count != `ETPM_TIMER_MAX) count <= count + 16'h1; // [R02]
      end else begin
        pre <= pre + 24'h1;
      end
    end
  end

  a_timer_sat_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
    count == `ETPM_TIMER_MAX && !clear |=> count == `ETPM_TIMER_MAX)
    else $error("elapsed timer wrapped past its maximum");
endmodule : etpm_tick_timer

// ==== verilog/etpm_divider.sv ====
// Purpose: Sequential restoring divider, one quotient bit per cycle
// Assumes: Divisor nonzero; start is a one-cycle pulse while idle
// Notes:   Done pulses 40 enabled cycles after start
`timescale 1ns/1ps
module etpm_divider (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic [39:0] dividend,
  input  wire logic [39:0] divisor,
  output logic             done,
  output logic      [39:0] quotient
);
  logic [39:0] rem;
  logic [5:0]  left;
  logic [40:0] trial;

  assign trial = {rem, quotient[39]} - {1'b0, divisor};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rem      <= 40'h0;
      quotient <= 40'h0;
      left     <= 6'h0;
      done     <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        rem      <= 40'h0;
        quotient <= dividend;
        left     <= 6'h28;
      end else if (left != 6'h0) begin
        left <= left - 6'h1;
        done <= (left == 6'h1);
        if (!trial[40]) begin
          rem      <= trial[39:0];
          quotient <= {quotient[38:0], 1'b1};
        end else begin
          rem      <= {rem[38:0], quotient[39]};
          quotient <= {quotient[38:0], 1'b0};
        end
      end
    end
  end
endmodule : etpm_divider

// ==== verilog/etpm_top.sv ====
// Purpose: Elapsed timer and period meter behind an AXI4-Lite slave
// Assumes: sig_in is synchronous to aclk; ce low freezes every flop
// Notes:   One result store shared by timer stores and period results
`timescale 1ns/1ps
`include "etpm_cfg.svh"
module etpm_top #(
  parameter int TIMER_STEP_CYC = `ETPM_TIMER_STEP_NS / `ETPM_CLK_NS,
  parameter int TMO_UNIT_CYC   = `ETPM_TMO_UNIT_NS / `ETPM_CLK_NS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        sig_in,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);
  etpm_pkg::etpm_mcfg_t  mcfg;
  etpm_pkg::etpm_mcfg_t  run_cfg;
  etpm_pkg::etpm_state_t st;
  logic [15:0] cyc_req;
  logic [15:0] run_cyc;
  logic [15:0] tmo_req;
  logic [3:0]  dest;
  logic [3:0]  tcmd_loc;
  logic [31:0] mult;
  logic [31:0] offs;
  logic [31:0] value;
  logic [2:0]  status;
  logic [2:0]  mask;
  logic [2:0]  st_set;
  logic [2:0]  st_clr;
  logic [31:0] mem [`ETPM_LOCS];
  logic        aw_hold;
  logic        w_hold;
  logic        next_aw_hold;
  logic        next_w_hold;
  logic        wr_fire;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [32:0] wr_cur;
  logic [31:0] wr_val;
  logic [32:0] rd_cur;
  logic        tmr_clear;
  logic        tpend;
  logic [15:0] tmr;
  logic        start_p;
  logic        cfg_ok;
  logic [7:0]  rep;
  logic [15:0] edges;
  logic [15:0] tmo_cnt;
  logic [23:0] pre;
  logic [36:0] cyc;
  logic        tmo_hit;
  logic        tmo_err;
  logic        flt_lvl;
  logic        rise;
  logic [11:0] flt_cnt;
  logic [11:0] flen;
  logic        div_start;
  logic        div_done;
  logic [39:0] div_a;
  logic [39:0] div_b;
  logic [39:0] div_q;
  logic [3:0]  st_idx;
  logic        irq_next;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic is_mem(input logic [11:0] a);
    return (a & `ETPM_MEM_MASK) == `ETPM_MEM_BASE;
  endfunction : is_mem

  // Returns {mapped, data}; shared by the read path and byte-merge on writes
  function automatic logic [32:0] rd_reg(input logic [11:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0};
    if (is_mem(a)) r[31:0] = mem[a[5:2]];
    else begin
      case ({a[11:2], 2'b00})
        `ETPM_A_CTRL: r[31:0] = {31'h0, st != etpm_pkg::S_IDLE};
        `ETPM_A_CFG:  r[31:0] = mcfg;
        `ETPM_A_CYC:  r[31:0] = {16'h0, cyc_req};
        `ETPM_A_TMO:  r[31:0] = {16'h0, tmo_req};
        `ETPM_A_DEST: r[31:0] = {28'h0, dest};
        `ETPM_A_MULT: r[31:0] = mult;
        `ETPM_A_OFFS: r[31:0] = offs;
        `ETPM_A_TCMD: r[31:0] = {28'h0, tcmd_loc};
        `ETPM_A_COMP: r[31:0] = 32'h0;
        `ETPM_A_ELAP: r[31:0] = {16'h0, tmr};
        `ETPM_A_STAT: r[31:0] = {29'h0, status};
        `ETPM_A_MASK: r[31:0] = {29'h0, mask};
        default:      r[32] = 1'b0;
      endcase
    end
    return r;
  endfunction : rd_reg

  function automatic logic range_ok(input logic [3:0] rc);
    return rc >= `ETPM_RANGE_1 && rc <= `ETPM_RANGE_4;
  endfunction : range_ok

  // Glitch filter of a quarter period at the range's top frequency
  function automatic logic [11:0] filt_len(input logic [3:0] rc);
    case (rc)
      `ETPM_RANGE_1: return 12'(`ETPM_FILT(`ETPM_FMAX_R1_KHZ));
      `ETPM_RANGE_2: return 12'(`ETPM_FILT(`ETPM_FMAX_R2_KHZ));
      `ETPM_RANGE_3: return 12'(`ETPM_FILT(`ETPM_FMAX_R3_KHZ));
      `ETPM_RANGE_4: return 12'(`ETPM_FILT(`ETPM_FMAX_R4_KHZ));
      default:       return 12'h001;
    endcase
  endfunction : filt_len

  function automatic logic [31:0] scale(input logic [31:0] v, input logic [31:0] m,
                                        input logic [31:0] o);
    logic signed [63:0] p;
    p = 64'($signed({1'b0, v})) * 64'($signed(m));
    return 32'(p >>> `ETPM_MULT_FRAC) + o;
  endfunction : scale

  // Write channel: address and data land in either order, then one response
  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_cur  = rd_reg(aw_addr);
  assign wr_val  = merge(wr_cur[31:0], w_data, w_strb);
  assign rd_cur  = rd_reg(s_axi_araddr);

  always_comb begin
    next_aw_hold = aw_hold || (s_axi_awvalid && s_axi_awready);
    next_w_hold  = w_hold || (s_axi_wvalid && s_axi_wready);
    if (wr_fire) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_addr       <= 12'h0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ETPM_RESP_OKAY;
    end else if (ce) begin
      aw_hold       <= next_aw_hold;
      w_hold        <= next_w_hold;
      s_axi_awready <= !next_aw_hold;
      s_axi_wready  <= !next_w_hold;
      if (s_axi_awvalid && s_axi_awready) aw_addr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        // The result store is read-only from the bus
        s_axi_bresp  <= (wr_cur[32] && !is_mem(aw_addr)) ? `ETPM_RESP_OKAY : `ETPM_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one outstanding read, answered the cycle after it is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `ETPM_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_cur[31:0];
        s_axi_rresp   <= rd_cur[32] ? `ETPM_RESP_OKAY : `ETPM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mcfg    <= `ETPM_CFG_RST;
      cyc_req <= 16'h1;
      tmo_req <= 16'h1;
      dest    <= 4'h0;
      mult    <= `ETPM_MULT_RST;
      offs    <= 32'h0;
      mask    <= 3'h0;
    end else if (ce && wr_fire) begin
      case ({aw_addr[11:2], 2'b00})
        `ETPM_A_CFG:  mcfg    <= wr_val & `ETPM_CFG_MASK;
        `ETPM_A_CYC:  cyc_req <= wr_val[15:0];
        `ETPM_A_TMO:  tmo_req <= wr_val[15:0]; // [R07]
        `ETPM_A_DEST: dest    <= wr_val[3:0];
        `ETPM_A_MULT: mult    <= wr_val;
        `ETPM_A_OFFS: offs    <= wr_val;
        `ETPM_A_MASK: mask    <= wr_val[2:0];
        default: ;
      endcase
    end
  end

  assign start_p = wr_fire && {aw_addr[11:2], 2'b00} == `ETPM_A_CTRL &&
                   w_strb[0] && w_data[`ETPM_CTRL_GO];
  assign cfg_ok  = range_ok(mcfg.range) && cyc_req != 16'h0 && mcfg.reps != 8'h0; // [R09]

  // Both a zero-location timer command and the run-mode compile clear the single timer
  assign tmr_clear = wr_fire && w_strb[0] &&
                     (({aw_addr[11:2], 2'b00} == `ETPM_A_TCMD && w_data[3:0] == 4'h0) || // [R04]
                      ({aw_addr[11:2], 2'b00} == `ETPM_A_COMP &&
                       w_data == `ETPM_COMPILE_RUN)); // [R03]

  etpm_tick_timer #(
    .STEP_CYC(TIMER_STEP_CYC)
  ) u_timer (
    .aclk   (aclk),
    .aresetn(aresetn),
    .ce     (ce),
    .clear  (tmr_clear),
    .count  (tmr)
  ); // [R01]

  // A timer store waits for any engine store to finish; a newer command wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tpend    <= 1'b0;
      tcmd_loc <= 4'h0;
    end else if (ce) begin
      if (wr_fire && w_strb[0] && {aw_addr[11:2], 2'b00} == `ETPM_A_TCMD &&
          w_data[3:0] != 4'h0) begin
        tpend    <= 1'b1; // [R04]
        tcmd_loc <= w_data[3:0];
      end else if (st != etpm_pkg::S_STORE) begin
        tpend <= 1'b0;
      end
    end
  end

  assign st_idx = dest + rep[3:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `ETPM_LOCS; i++) mem[i] <= 32'h0;
    end else if (ce) begin
      if (st == etpm_pkg::S_STORE) mem[st_idx] <= value; // [R10]
      else if (tpend) mem[tcmd_loc] <= {16'h0, tmr}; // [R04]
    end
  end

  assign flen = filt_len(run_cfg.range); // [R09]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flt_lvl <= 1'b0;
      flt_cnt <= 12'h0;
      rise    <= 1'b0;
    end else if (ce) begin
      rise <= 1'b0;
      if (sig_in == flt_lvl) begin
        flt_cnt <= 12'h0;
      end else if (flt_cnt >= flen - 12'h1) begin
        flt_lvl <= sig_in;
        flt_cnt <= 12'h0;
        rise    <= sig_in;
      end else begin
        flt_cnt <= flt_cnt + 12'h1;
      end
    end
  end

  assign tmo_hit = tmo_cnt >= tmo_req &&
                   (st == etpm_pkg::S_ARM || st == etpm_pkg::S_COUNT); // [R06]

  etpm_divider u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .start   (div_start),
    .dividend(div_a),
    .divisor (div_b),
    .done    (div_done),
    .quotient(div_q)
  );

  // Counting whole 8 ns clocks keeps the raw step finer than the 60 ns needed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st        <= etpm_pkg::S_IDLE;
      run_cfg   <= `ETPM_CFG_RST;
      run_cyc   <= 16'h1;
      rep       <= 8'h0;
      edges     <= 16'h0;
      cyc       <= 37'h0;
      value     <= 32'h0;
      tmo_err   <= 1'b0;
      div_start <= 1'b0;
      div_a     <= 40'h0;
      div_b     <= 40'h1;
      pre       <= 24'h0;
      tmo_cnt   <= 16'h0;
    end else if (ce) begin
      div_start <= 1'b0;
      if (pre == 24'(TMO_UNIT_CYC - 1)) begin
        pre <= 24'h0;
        if (tmo_cnt != `ETPM_TMO_MAX) tmo_cnt <= tmo_cnt + 16'h1;
      end else begin
        pre <= pre + 24'h1;
      end
      unique case (st)
        etpm_pkg::S_IDLE: begin
          if (start_p && cfg_ok) begin
            st      <= etpm_pkg::S_ARM;
            run_cfg <= mcfg;
            run_cyc <= cyc_req;
            rep     <= 8'h0;
            pre     <= 24'h0;
            tmo_cnt <= 16'h0;
          end
        end
        etpm_pkg::S_ARM: begin
          if (tmo_hit) begin
            value   <= `ETPM_ERR_VAL; // [R06]
            tmo_err <= 1'b1;
            st      <= etpm_pkg::S_STORE;
          end else if (rise) begin
            st    <= etpm_pkg::S_COUNT;
            cyc   <= 37'h0;
            edges <= 16'h0;
          end
        end
        etpm_pkg::S_COUNT: begin
          cyc <= cyc + 37'h1;
          if (tmo_hit) begin
            value   <= `ETPM_ERR_VAL; // [R06]
            tmo_err <= 1'b1;
            st      <= etpm_pkg::S_STORE;
          end else if (rise) begin
            edges <= edges + 16'h1;
            if (edges + 16'h1 == run_cyc) begin
              st        <= etpm_pkg::S_DIV1;
              div_start <= 1'b1;
              div_a     <= {cyc + 37'h1, 3'b000}; // [R05]
              div_b     <= {24'h0, run_cyc};
            end
          end
        end
        etpm_pkg::S_DIV1: begin
          if (div_done) begin
            if (run_cfg.freq) begin
              st        <= etpm_pkg::S_DIV2; // [R08]
              div_start <= 1'b1;
              div_a     <= `ETPM_NS_PER_S; // [R11]
              div_b     <= div_q;
            end else begin
              value <= div_q[31:0];
              st    <= etpm_pkg::S_SCALE;
            end
          end
        end
        etpm_pkg::S_DIV2: begin
          if (div_done) begin
            value <= div_q[31:0]; // [R11]
            st    <= etpm_pkg::S_SCALE;
          end
        end
        etpm_pkg::S_SCALE: begin
          value <= scale(value, mult, offs);
          st    <= etpm_pkg::S_STORE;
        end
        etpm_pkg::S_STORE: begin
          tmo_err <= 1'b0;
          pre     <= 24'h0;
          tmo_cnt <= 16'h0;
          rep     <= rep + 8'h1; // [R10]
          st      <= (rep + 8'h1 == run_cfg.reps) ? etpm_pkg::S_IDLE : etpm_pkg::S_ARM;
        end
        default: st <= etpm_pkg::S_IDLE;
      endcase
    end
  end

  // Sticky events; a new event beats a clear written in the same cycle
  always_comb begin
    st_set = 3'h0;
    st_set[`ETPM_ST_DONE] = st == etpm_pkg::S_STORE && rep + 8'h1 == run_cfg.reps;
    st_set[`ETPM_ST_TMO]  = st == etpm_pkg::S_STORE && tmo_err;
    st_set[`ETPM_ST_BAD]  = st == etpm_pkg::S_IDLE && start_p && !cfg_ok;
    st_clr = (wr_fire && {aw_addr[11:2], 2'b00} == `ETPM_A_STAT) ? wr_val[2:0] : 3'h0;
  end

  assign irq_next = |(status & mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= 3'h0;
      irq    <= 1'b0;
    end else if (ce) begin
      status <= (status & ~st_clr) | st_set;
      irq    <= irq_next;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_timer_zero_cmd: assert property (ce && tmr_clear |=> tmr == 16'h0) // [R04]
    else $error("timer not cleared by a zero-location command");
  a_compile_run_clr: assert property (ce && wr_fire && w_strb[0] && // [R03]
    {aw_addr[11:2], 2'b00} == `ETPM_A_COMP && w_data == `ETPM_COMPILE_RUN |=> tmr == 16'h0)
    else $error("compile-and-run did not clear the timer");
  a_compile_keep_run: assert property (ce && wr_fire && !tmr_clear && // [R03]
    {aw_addr[11:2], 2'b00} == `ETPM_A_COMP |=> tmr >= $past(tmr))
    else $error("compile-only disturbed the timer");
  a_error_value_stored: assert property (st == etpm_pkg::S_STORE && tmo_err // [R06]
    |-> value == `ETPM_ERR_VAL)
    else $error("timed-out repetition stored something other than the error value");
  a_timeout_ends_wait: assert property (ce && tmo_hit |=> st == etpm_pkg::S_STORE) // [R06]
    else $error("timeout did not end the wait");
  a_store_consecutive: assert property (ce && st == etpm_pkg::S_STORE // [R10]
    |=> mem[$past(st_idx)] == $past(value))
    else $error("result not written at destination plus repetition");
  a_period_dividend: assert property (ce && st == etpm_pkg::S_COUNT && !tmo_hit && rise && // [R05]
    edges + 16'h1 == run_cyc |=> div_a == {$past(cyc) + 37'h1, 3'b000} && div_start)
    else $error("period dividend is not the elapsed time in ns");
  a_freq_select: assert property (ce && st == etpm_pkg::S_DIV1 && div_done // [R08]
    |=> (st == etpm_pkg::S_DIV2) == run_cfg.freq)
    else $error("output option did not pick the result type");
  a_range_checked: assert property (st != etpm_pkg::S_IDLE |-> range_ok(run_cfg.range)) // [R09]
    else $error("measurement running with an illegal range code");
  a_irq_follows: assert property (ce |=> irq == $past(irq_next))
    else $error("interrupt output does not follow masked status");
endmodule : etpm_top

// ==== test/etpm_sig_src.sv ====
// Purpose: Square wave source standing in for the measured signal
// Assumes: Half period given in aclk cycles, edges on aclk
// Notes:   When off it toggles every cycle, so no stale level passes the filter
`timescale 1ns/1ps
module etpm_sig_src (
  input  wire logic        aclk,
  input  wire logic        en,
  input  wire logic [15:0] half,
  output logic             sig
);
  logic        wrap;
  logic [15:0] cnt = 16'h0000;
  initial sig = 1'b0;
  assign wrap = !en || cnt == half - 16'h0001;
  always @(posedge aclk) begin // While en is high, stays under the range 4 limit for a half of 313 or more
    cnt <= wrap ? 16'h0000 : cnt + 16'h0001;
    if (wrap) sig <= ~sig;
  end
endmodule : etpm_sig_src

// ==== test/elapsed_timer_and_period_meter_tb.sv ====
// Purpose: Bus-driven checks of the elapsed timer and period meter
// Assumes: Short timer step (8) and timeout unit (100 cycles)
// Notes:   Source period 640 cycles = 5120 ns, just under 200 kHz
`timescale 1ns/1ps
`include "etpm_cfg.svh"
module elapsed_timer_and_period_meter_tb;
  logic        aclk, aresetn, en, sig, awvalid, wvalid, arvalid, irq, ce, bready, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v, e;
  logic [1:0]  bresp, rresp, r;
  int          failures, checks_done;
  etpm_top #(.TIMER_STEP_CYC(8), .TMO_UNIT_CYC(100)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .sig_in(sig),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq));
  etpm_sig_src i_src (.aclk(aclk), .en(en), .half(16'h0140), .sig(sig));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
  endtask : rd
  task automatic run(input logic [31:0] cfg, input logic [31:0] dest);
    wr(`ETPM_A_STAT, 32'h00000007);
    wr(`ETPM_A_DEST, dest);
    wr(`ETPM_A_CFG, cfg);
    wr(`ETPM_A_CTRL, 32'h00000001);
    do rd(`ETPM_A_STAT); while (v[0] !== 1'b1);
  endtask : run
  task automatic results;
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    results;
  end
  initial begin
    {aresetn, en, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {ce, bready, rready} = 3'b111;
    failures = 0;
    checks_done = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(`ETPM_A_COMP, `ETPM_COMPILE_RUN);
    rd(`ETPM_A_ELAP);
    chk(32'(v < 32'h2), 32'h1);
    chk({30'h0, r}, 32'h0);
    repeat (100) @(posedge aclk);
    wr(`ETPM_A_COMP, `ETPM_COMPILE_KEEP);
    rd(`ETPM_A_ELAP);
    chk(32'(v > 32'hb), 32'h1);
    wr(`ETPM_A_TCMD, 32'h0);
    rd(`ETPM_A_ELAP);
    chk(32'(v < 32'h2), 32'h1);
    // Clock enable low must freeze the timer prescaler as well
    ce <= 1'b0;
    repeat (40) @(posedge aclk);
    ce <= 1'b1;
    rd(`ETPM_A_ELAP);
    chk(32'(v < 32'h3), 32'h1);
    repeat (64) @(posedge aclk);
    wr(`ETPM_A_TCMD, 32'h5);
    rd(`ETPM_A_ELAP);
    e = v;
    rd(12'h114);
    chk(32'(e - v < 32'h2 && v > 32'h6), 32'h1);
    rd(12'h110);
    chk(v, 32'h0);
    wr(12'h100, 32'h1);
    chk({30'h0, r}, 32'h2);
    wr(`ETPM_A_MASK, 32'h1);
    wr(`ETPM_A_CYC, 32'h2);
    wr(`ETPM_A_TMO, 32'h28); // Covers three cycles plus margin
    en <= 1'b1;
    run(32'h00000403, 32'he);
    chk({31'h0, irq}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      rd(12'h100 + 12'(((14 + i) % 16) * 4));
      chk(v, 32'h00001400);
    end
    // Scale 2.0 plus 1 after the division: 2 * 195312 + 1
    wr(`ETPM_A_MULT, 32'h00020000);
    wr(`ETPM_A_OFFS, 32'h00000001);
    run(32'h00001401, 32'h2);
    rd(12'h108);
    chk(v, 32'h0005f5e1);
    en <= 1'b0;
    wr(`ETPM_A_TMO, 32'h1);
    run(32'h00000401, 32'h3);
    chk(v & 32'h7, 32'h3);
    rd(12'h10c);
    chk(v, `ETPM_ERR_VAL);
    wr(`ETPM_A_STAT, 32'h7);
    @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    for (int c = 0; c < 2; c++) begin
      wr(`ETPM_A_CFG, c ? 32'h00000501 : 32'h00000001);
      wr(`ETPM_A_CTRL, 32'h1);
      rd(`ETPM_A_STAT);
      chk(v & 32'h4, 32'h4);
      wr(`ETPM_A_STAT, 32'h7);
    end
    results;
  end
endmodule : elapsed_timer_and_period_meter_tb
